/* File: logic/mbsch_pkg.sv */
// Constants for the slave command handler: function codes, exception codes, timing.
// Assumes a 100 MHz core clock and a byte-level UART outside the block.
package mbsch_pkg;
    localparam int CLK_HZ = 100_000_000;
    localparam logic [7:0] FC_READ = 8'h03;
    localparam logic [7:0] FC_WRITE_EE = 8'h06;
    localparam logic [7:0] FC_DIAG = 8'h08;
    localparam logic [7:0] FC_WRITE = 8'h41;
    localparam logic [7:0] FC_EXC_BIT = 8'h80;
    localparam logic [7:0] EX_ILL_FUNC = 8'h01;
    localparam logic [7:0] EX_ILL_ADDR = 8'h02;
    localparam logic [7:0] EX_ILL_FRAME = 8'h03;
    localparam logic [7:0] EX_SLAVE_PROT = 8'h04;
    localparam logic [7:0] BCAST_ADDR = 8'h00;
    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [15:0] CRC_POLY = 16'ha001;
    localparam logic [15:0] FREQ_SETPOINT_REG = 16'h7015;
    localparam int MIN_LEGAL_LEN = 3;
    localparam int REQ_LEN = 8;
    localparam int MAX_READ_REGS = 16;
    localparam logic [15:0] DIAG_ECHO_SUB = 16'h0000;
    // Timeout setting unit: 1 ms
    localparam int TMO_UNIT_NS = 1_000_000;
    localparam int TMO_UNIT_CYC = TMO_UNIT_NS / 10;
    localparam int FIFO_DEPTH = 32;
endpackage

/* File: logic/mbsch_fifo.sv */
// Byte FIFO between the handler and the transmitter.
// Assumes one clock; drain side may stall at will.
`timescale 1ns/1ps
module mbsch_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    if (WIDTH < 1 || DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_shape
        $error("WIDTH must be positive and DEPTH a power of two");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic do_wr;
    logic do_rd;
    assign in_ready = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
    assign out_valid = wr_ptr != rd_ptr;
    assign do_wr = in_valid && in_ready;
    assign do_rd = out_valid && out_ready;
    assign out_data = mem[rd_ptr[AW-1:0]];
    always_ff @(posedge core_clk) begin
        if (do_wr) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (do_wr) wr_ptr <= wr_ptr + 1'b1;
            if (do_rd) rd_ptr <= rd_ptr + 1'b1;
        end
    end
endmodule

/* File: logic/mbsch_handler.sv */
// Slave command handler: frame check, function execution, reply build, timeout.
// Assumes a byte receiver giving rx_valid pulses and a transmitter draining tx_*.
`timescale 1ns/1ps
// Overview of operation
// - Flag timeout when time since last valid frame exceeds setting; zero disables.
// - Restart the timeout interval on each valid frame addressed here.
// - Valid frame needs correct function code, length and CRC from master.
// - EEPROM-backed requests may reply later than the normal response delay.
// - Function 41h writes register and echoes request including its CRC.
// - Exception reply: address, function with top bit set, code, CRC.
// - Internal unrecoverable fault gives exception code 04.
// - Read 03h replies address, function, byte count 2N, values high first, CRC.
// - Diagnostic 08h subfunction 0000 echoes the complete request.
// - Function 06h writes register, stores to EEPROM, echoes request.
// - Frequency setpoint register takes hundredths of hertz.
// - Frames delimited by 3.5 char idle; gap over 1.5 chars is error.
// - Discard frames failing address or minimum length silently.
module mbsch_handler
    import mbsch_pkg::*;
#(
    parameter int CHAR_CYC = 104167
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [7:0] slave_addr,
    input wire logic [15:0] comm_timeout_setting,
    input wire logic [15:0] response_delay_setting,
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    output logic tx_valid,
    input wire logic tx_ready,
    output logic [7:0] tx_data,
    output logic reg_req,
    output logic reg_we,
    output logic ee_store,
    output logic [15:0] reg_addr,
    output logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_ack,
    input wire logic reg_fault,
    input wire logic reg_bad_addr,
    output logic freq_setpoint_we,
    output logic [15:0] freq_setpoint,
    output logic comm_timeout
);
    localparam int GAP_FRAME = (CHAR_CYC * 7 + 1) / 2;
    localparam int GAP_ERR = (CHAR_CYC * 3 + 1) / 2;
    if (CHAR_CYC < 2) begin : g_bad_char
        $error("CHAR_CYC too small");
    end
    typedef enum logic [2:0] {
        MBSCH_IDLE = 3'b000,
        MBSCH_RECV = 3'b001,
        MBSCH_EXEC = 3'b010,
        MBSCH_WAIT = 3'b011,
        MBSCH_DELAY = 3'b100,
        MBSCH_SEND = 3'b101
    } mbsch_state_t;
    mbsch_state_t state;
    logic [7:0] rbuf [REQ_LEN];
    logic [7:0] obuf [5 + 2*MAX_READ_REGS];
    logic [5:0] rcount;
    logic [5:0] olen;
    logic [5:0] oidx;
    logic [5:0] widx;
    logic [15:0] rcrc;
    logic [15:0] ocrc;
    logic [31:0] gap_cnt;
    logic gap_err;
    logic [31:0] dly_cnt;
    logic [47:0] tmo_cnt;
    logic [15:0] tmo_ms;
    logic [15:0] rd_cnt;
    logic fifo_ready;
    logic fifo_valid;
    logic [7:0] fifo_data;
    logic crc_ok;
    logic legal;
    logic fc_known;
    logic frame_end;
    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {8'h00, d};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction
    assign frame_end = (state == MBSCH_RECV) && (gap_cnt >= 32'(GAP_FRAME));
    assign crc_ok = (rcrc == 16'h0000);
    assign legal = (rcount >= 6'(MIN_LEGAL_LEN))
        && (rbuf[0] == slave_addr || rbuf[0] == BCAST_ADDR);
    assign fc_known = rbuf[1] == FC_READ || rbuf[1] == FC_WRITE
        || rbuf[1] == FC_WRITE_EE || rbuf[1] == FC_DIAG;
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            gap_cnt <= '0;
        end else if (rx_valid) begin
            gap_cnt <= '0;
        end else if (gap_cnt != 32'hffffffff) begin
            gap_cnt <= gap_cnt + 1'b1;
        end
    end
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state <= MBSCH_IDLE;
            rcount <= '0;
            rcrc <= CRC_INIT;
            gap_err <= 1'b0;
            olen <= '0;
            widx <= '0;
            reg_req <= 1'b0;
            reg_we <= 1'b0;
            ee_store <= 1'b0;
            reg_addr <= '0;
            reg_wdata <= '0;
            rd_cnt <= '0;
            dly_cnt <= '0;
            tmo_ms <= '0;
        end else begin
            unique case (state)
                MBSCH_IDLE: begin
                    rcount <= '0;
                    rcrc <= CRC_INIT;
                    gap_err <= 1'b0;
                    if (rx_valid && gap_cnt >= 32'(GAP_FRAME)) begin
                        rbuf[0] <= rx_data;
                        rcount <= 6'd1;
                        rcrc <= crc_byte(CRC_INIT, rx_data);
                        state <= MBSCH_RECV;
                    end
                end
                MBSCH_RECV: begin
                    if (rx_valid) begin
                        if (gap_cnt > 32'(GAP_ERR)) gap_err <= 1'b1;
                        if (rcount < 6'(REQ_LEN)) rbuf[rcount[2:0]] <= rx_data;
                        if (rcount != 6'h3f) rcount <= rcount + 1'b1;
                        rcrc <= crc_byte(rcrc, rx_data);
                    end else if (frame_end) begin
                        if (!legal || gap_err) begin
                            state <= MBSCH_IDLE;
                        end else begin
                            state <= MBSCH_EXEC;
                        end
                    end
                end
                MBSCH_EXEC: begin
                    obuf[0] <= rbuf[0];
                    obuf[1] <= rbuf[1] | FC_EXC_BIT;
                    olen <= 6'd3;
                    reg_addr <= {rbuf[2], rbuf[3]};
                    reg_wdata <= {rbuf[4], rbuf[5]};
                    rd_cnt <= {rbuf[4], rbuf[5]};
                    dly_cnt <= '0;
                    tmo_ms <= '0;
                    widx <= 6'd3;
                    state <= MBSCH_DELAY;
                    if (rcount != 6'(REQ_LEN) || !crc_ok) begin
                        obuf[2] <= EX_ILL_FRAME;
                    end else if (rbuf[1] == FC_WRITE || rbuf[1] == FC_WRITE_EE) begin
                        reg_req <= 1'b1;
                        reg_we <= 1'b1;
                        ee_store <= (rbuf[1] == FC_WRITE_EE);
                        state <= MBSCH_WAIT;
                    end else if (rbuf[1] == FC_READ) begin
                        if ({rbuf[4], rbuf[5]} == 16'h0000
                            || {rbuf[4], rbuf[5]} > 16'(MAX_READ_REGS)) begin
                            obuf[2] <= EX_ILL_ADDR;
                        end else begin
                            obuf[1] <= FC_READ;
                            obuf[2] <= {rbuf[5][6:0], 1'b0};
                            reg_req <= 1'b1;
                            reg_we <= 1'b0;
                            state <= MBSCH_WAIT;
                        end
                    end else if (rbuf[1] == FC_DIAG && {rbuf[2], rbuf[3]} == DIAG_ECHO_SUB) begin
                        for (int i = 0; i < REQ_LEN; i++) obuf[i] <= rbuf[i];
                        // Echo CRC is regenerated on send, so it matches the request's
                        olen <= 6'(REQ_LEN - 2);
                    end else begin
                        obuf[2] <= EX_ILL_FUNC;
                    end
                end
                MBSCH_WAIT: begin
                    if (reg_ack) begin
                        reg_req <= 1'b0;
                        reg_we <= 1'b0;
                        ee_store <= 1'b0;
                        if (reg_fault || reg_bad_addr) begin
                            obuf[1] <= rbuf[1] | FC_EXC_BIT;
                            obuf[2] <= reg_fault ? EX_SLAVE_PROT : EX_ILL_ADDR;
                            olen <= 6'd3;
                            state <= MBSCH_DELAY;
                        end else if (reg_we) begin
                            for (int i = 0; i < REQ_LEN; i++) obuf[i] <= rbuf[i];
                            olen <= 6'(REQ_LEN - 2);
                            state <= MBSCH_DELAY;
                        end else begin
                            obuf[widx] <= reg_rdata[15:8];
                            obuf[widx + 6'd1] <= reg_rdata[7:0];
                            widx <= widx + 6'd2;
                            if (rd_cnt == 16'd1) begin
                                olen <= widx + 6'd2;
                                state <= MBSCH_DELAY;
                            end else begin
                                rd_cnt <= rd_cnt - 1'b1;
                                reg_addr <= reg_addr + 1'b1;
                                reg_req <= 1'b1;
                            end
                        end
                    end
                    dly_cnt <= '0;
                    tmo_ms <= '0;
                end
                MBSCH_DELAY: begin
                    if (dly_cnt == 32'(TMO_UNIT_CYC - 1)) begin
                        dly_cnt <= '0;
                        tmo_ms <= tmo_ms + 1'b1;
                    end else begin
                        dly_cnt <= dly_cnt + 1'b1;
                    end
                    if (rbuf[0] == BCAST_ADDR) begin
                        state <= MBSCH_IDLE;
                    end else if (tmo_ms >= response_delay_setting) begin
                        oidx <= '0;
                        ocrc <= CRC_INIT;
                        state <= MBSCH_SEND;
                    end
                end
                MBSCH_SEND: begin
                    if (fifo_ready) begin
                        if (oidx == olen + 6'd1) state <= MBSCH_IDLE;
                        else if (oidx < olen) ocrc <= crc_byte(ocrc, obuf[oidx]);
                        oidx <= oidx + 1'b1;
                    end
                end
                default: state <= MBSCH_IDLE;
            endcase
            if (state != MBSCH_EXEC && state != MBSCH_WAIT) begin
                reg_req <= 1'b0;
                reg_we <= 1'b0;
                ee_store <= 1'b0;
            end
        end
    end
    always_comb begin
        fifo_valid = (state == MBSCH_SEND);
        if (oidx < olen) fifo_data = obuf[oidx];
        else if (oidx == olen) fifo_data = ocrc[7:0];
        else fifo_data = ocrc[15:8];
    end
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            freq_setpoint_we <= 1'b0;
            freq_setpoint <= '0;
        end else begin
            freq_setpoint_we <= 1'b0;
            if (state == MBSCH_WAIT && reg_ack && reg_we && !reg_fault && !reg_bad_addr
                && reg_addr == FREQ_SETPOINT_REG) begin
                freq_setpoint_we <= 1'b1;
                freq_setpoint <= reg_wdata;
            end
        end
    end
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            tmo_cnt <= '0;
            comm_timeout <= 1'b0;
        end else if (state == MBSCH_EXEC && rcount == 6'(REQ_LEN) && crc_ok
                     && rbuf[0] == slave_addr && fc_known) begin
            tmo_cnt <= '0;
            comm_timeout <= 1'b0;
        end else if (comm_timeout_setting == 16'h0000) begin
            tmo_cnt <= '0;
            comm_timeout <= 1'b0;
        end else begin
            if (tmo_cnt != 48'hffffffffffff) tmo_cnt <= tmo_cnt + 1'b1;
            if (tmo_cnt > 48'(comm_timeout_setting) * 48'(TMO_UNIT_CYC)) begin
                comm_timeout <= 1'b1;
            end
        end
    end
    mbsch_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .in_valid(fifo_valid),
        .in_ready(fifo_ready),
        .in_data(fifo_data),
        .out_valid(tx_valid),
        .out_ready(tx_ready),
        .out_data(tx_data)
    );
endmodule

/* File: dv/mbsch_monitor.sv */
// Port checks for the slave command handler.
// Assumes binding onto mbsch_handler in the single core_clk domain.
`timescale 1ns/1ps
module mbsch_monitor
    import mbsch_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [15:0] comm_timeout_setting,
    input wire logic rx_valid,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic [7:0] tx_data,
    input wire logic reg_req,
    input wire logic reg_we,
    input wire logic ee_store,
    input wire logic [15:0] reg_addr,
    input wire logic reg_ack,
    input wire logic freq_setpoint_we,
    input wire logic [15:0] freq_setpoint,
    input wire logic comm_timeout
);
    tmo_zero_off_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        comm_timeout_setting == 16'h0000 && $past(comm_timeout_setting) == 16'h0000
        |-> !comm_timeout) else $error("timeout flag while disabled");
    tmo_cause_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        $rose(comm_timeout) |-> comm_timeout_setting != 16'h0000) else $error("timeout at zero");
    req_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        reg_req && !reg_ack |=> reg_req && $stable(reg_addr) && $stable(reg_we))
        else $error("register request dropped early");
    tx_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)) else $error("reply byte lost");
    ee_write_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        ee_store |-> reg_req && reg_we) else $error("store without write");
    freq_load_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        $changed(freq_setpoint) |-> freq_setpoint_we) else $error("setpoint changed silently");
    freq_addr_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        freq_setpoint_we |-> reg_addr == FREQ_SETPOINT_REG) else $error("setpoint wrong address");
    frame_gap_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        rx_valid |=> (!reg_req) [*8]) else $error("request inside frame");
    reset_quiet_a: assert property (@(posedge core_clk)
        sys_rst |=> !tx_valid && !reg_req && !comm_timeout) else $error("outputs active in reset");
endmodule
bind mbsch_handler mbsch_monitor i_mon (.core_clk, .sys_rst, .comm_timeout_setting, .rx_valid,
    .tx_valid, .tx_ready, .tx_data, .reg_req, .reg_we, .ee_store, .reg_addr, .reg_ack,
    .freq_setpoint_we, .freq_setpoint, .comm_timeout);

/* File: dv/mbsch_master_model.sv */
// Master station model: sends request bytes, collects reply bytes.
// Assumes one byte per CHAR_CYC core_clk cycles on the receive side.
`timescale 1ns/1ps
module mbsch_master_model #(
    parameter int CHAR_CYC = 20
) (
    input wire logic core_clk,
    input wire logic stall,
    output logic [7:0] rx_data,
    output logic rx_valid,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [7:0] tx_data
);
    logic [7:0] got[$];
    logic [2:0] phase = 3'h0;
    initial begin
        rx_data = 8'h00;
        rx_valid = 1'b0;
        tx_ready = 1'b1;
    end
    // Slow drain takes one byte in eight
    always @(negedge core_clk) begin
        phase <= phase + 3'h1;
        tx_ready <= !stall || phase == 3'h7;
    end
    always @(posedge core_clk) begin
        if (tx_valid && tx_ready) begin
            got.push_back(tx_data);
        end
    end
    // Four idle characters lead each frame; bytes one character apart
    task automatic send(input logic [7:0] b[$]);
        repeat (4 * CHAR_CYC) @(negedge core_clk);
        foreach (b[i]) begin
            rx_data = b[i];
            rx_valid = 1'b1;
            @(negedge core_clk);
            rx_valid = 1'b0;
            rx_data = ~b[i];
            repeat (CHAR_CYC - 1) @(negedge core_clk);
        end
    endtask
endmodule

/* File: dv/modbus_slave_command_handler_test.sv */
// Self-checking bench for the slave command handler.
// Assumes a master model on the byte side and a register responder here.
`timescale 1ns/1ps
module modbus_slave_command_handler_test
    import mbsch_pkg::*;
();
    typedef logic [7:0] mbsch_bytes_t[$];
    logic core_clk, sys_rst, rx_valid, tx_valid, tx_ready, reg_req, reg_we, ee_store;
    logic reg_ack, reg_fault, reg_bad_addr, freq_setpoint_we, comm_timeout, stall, fault_on;
    logic wr_ee;
    logic [7:0] rx_data, tx_data;
    logic [15:0] comm_timeout_setting, reg_addr, reg_wdata, reg_rdata, freq_setpoint, wr_data;
    int n_errors, num_checks;
    mbsch_bytes_t fw = '{8'h01, 8'h41, 8'h70, 8'h15, 8'h13, 8'h88, 8'h3b, 8'h97};
    mbsch_bytes_t fe = '{8'h01, 8'h06, 8'h00, 8'h17, 8'h00, 8'h28, 8'h39, 8'hd0};
    mbsch_bytes_t fd = '{8'h01, 8'h08, 8'h00, 8'h00, 8'haa, 8'h55, 8'h5e, 8'h94};
    mbsch_bytes_t fr = '{8'h01, 8'h03, 8'h13, 8'h00, 8'h00, 8'h06, 8'hc1, 8'h4c};
    mbsch_handler #(.CHAR_CYC(20)) i_dut (.core_clk, .sys_rst, .slave_addr(8'h01),
        .comm_timeout_setting, .response_delay_setting(16'h0000), .rx_data, .rx_valid,
        .tx_valid, .tx_ready, .tx_data, .reg_req, .reg_we, .ee_store, .reg_addr, .reg_wdata,
        .reg_rdata, .reg_ack, .reg_fault, .reg_bad_addr, .freq_setpoint_we, .freq_setpoint,
        .comm_timeout);
    mbsch_master_model #(.CHAR_CYC(20)) i_master (.core_clk, .stall, .rx_data, .rx_valid,
        .tx_valid, .tx_ready, .tx_data);
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // Register side: one ack per request, read data hi = addr lo, lo = its inverse
    always @(negedge core_clk) begin
        reg_ack <= reg_req && !reg_ack;
        reg_rdata <= (reg_req && !reg_ack) ? {reg_addr[7:0], ~reg_addr[7:0]} : ~reg_rdata;
        reg_fault <= fault_on;
        reg_bad_addr <= reg_addr[15:12] == 4'hf;
        if (reg_req && !reg_ack && reg_we) begin
            wr_data <= reg_wdata;
            wr_ee <= ee_store;
        end
    end
    function automatic mbsch_bytes_t with_crc(input mbsch_bytes_t b);
        logic [15:0] c;
        c = CRC_INIT;
        foreach (b[i]) begin
            c = c ^ {8'h00, b[i]};
            for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
        end
        b.push_back(c[7:0]);
        b.push_back(c[15:8]);
        return b;
    endfunction
    task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (exp !== got) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d, errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic xact(input mbsch_bytes_t req, input mbsch_bytes_t exp);
        int n;
        n = 0;
        i_master.got.delete();
        i_master.send(req);
        while (i_master.got.size() < exp.size() && n < 4000) begin
            @(negedge core_clk);
            n++;
        end
        if (i_master.got.size() < exp.size()) begin
            n_errors++;
            $display("unexpected reply wait: expected %0d bytes, seen %0d", exp.size(),
                i_master.got.size());
            tally_and_finish();
        end
        repeat (300) @(negedge core_clk);
        check_val("reply length", 16'(exp.size()), 16'(i_master.got.size()));
        foreach (exp[i]) check_val("reply byte", {8'h00, exp[i]}, {8'h00, i_master.got[i]});
    endtask
    task automatic exc(input mbsch_bytes_t body, input logic [7:0] code);
        xact(with_crc(body), with_crc('{body[0], body[1] | FC_EXC_BIT, code}));
    endtask
    task automatic t_echo();
        xact(fw, fw);
        check_val("setpoint", 16'h1388, freq_setpoint);
        check_val("stored flag", 16'h0000, {15'h0, wr_ee});
        xact(fe, fe);
        check_val("stored data", 16'h0028, wr_data);
        check_val("stored flag", 16'h0001, {15'h0, wr_ee});
        xact(fd, fd);
    endtask
    task automatic t_discard();
        xact(with_crc('{8'h02, 8'h41, 8'h70, 8'h15, 8'h00, 8'h02}), '{});
        xact('{8'h01, 8'h41}, '{});
        check_val("setpoint", 16'h1388, freq_setpoint);
        xact(with_crc('{8'h00, 8'h41, 8'h70, 8'h15, 8'h00, 8'h03}), '{});
        check_val("setpoint", 16'h0003, freq_setpoint);
    endtask
    task automatic t_read();
        mbsch_bytes_t e;
        e = '{8'h01, 8'h03, 8'h0c};
        for (int i = 0; i < 6; i++) e = {e, 8'(i), ~8'(i)};
        stall = 1'b1;
        xact(fr, with_crc(e));
        stall = 1'b0;
    endtask
    task automatic t_fault();
        fault_on = 1'b1;
        xact(fw, '{8'h01, 8'hc1, 8'h04, 8'h70, 8'h53});
        xact(fr, '{8'h01, 8'h83, 8'h04, 8'h40, 8'hf3});
        xact(fe, '{8'h01, 8'h86, 8'h04, 8'h43, 8'ha3});
        fault_on = 1'b0;
    endtask
    task automatic t_exc();
        mbsch_bytes_t b;
        exc('{8'h01, 8'h07, 8'h00, 8'h00, 8'h00, 8'h01}, EX_ILL_FUNC);
        exc('{8'h01, 8'h03, 8'h13, 8'h00, 8'h00, 8'h00}, EX_ILL_ADDR);
        exc('{8'h01, 8'h03, 8'h13, 8'h00, 8'h00, 8'h11}, EX_ILL_ADDR);
        exc('{8'h01, 8'h03, 8'hf0, 8'h00, 8'h00, 8'h01}, EX_ILL_ADDR);
        b = fw;
        b[7] = 8'h00;
        xact(b, with_crc('{8'h01, 8'hc1, 8'h03}));
    endtask
    task automatic t_timeout();
        int n;
        n = 0;
        comm_timeout_setting = 16'h0001;
        xact(fd, fd);
        check_val("timeout early", 16'h0000, {15'h0, comm_timeout});
        while (comm_timeout !== 1'b1 && n < 101000) begin
            @(negedge core_clk);
            n++;
        end
        check_val("timeout window", 16'h0001, {15'h0, n > 99000 && n < 101000});
    endtask
    initial begin
        sys_rst = 1'b1;
        comm_timeout_setting = 16'h0000;
        {stall, fault_on, reg_ack, reg_fault, reg_bad_addr, wr_ee} = 6'h00;
        {reg_rdata, wr_data} = 32'h0000_0000;
        n_errors = 0;
        num_checks = 0;
        repeat (5) @(negedge core_clk);
        sys_rst = 1'b0;
        t_echo();
        t_discard();
        t_read();
        t_fault();
        t_exc();
        t_timeout();
        tally_and_finish();
    end
endmodule
